// ==== core/ledst_map.vh ====
// Constants for the LED startup test and dimming mode block
`ifndef LEDST_MAP_VH
`define LEDST_MAP_VH
`define LEDST_CLK_PERIOD_NS   10
`define LEDST_RESTART_MS      10
`define LEDST_RESTART_CYC     (`LEDST_RESTART_MS * 1000000 / `LEDST_CLK_PERIOD_NS)
`define LEDST_TEST_CYC        100000
`define LEDST_PWM_ON_MIN_NS   8000
`define LEDST_MODE_PWM        2'h0
`define LEDST_MODE_SERIAL     2'h1
`define LEDST_MODE_DC         2'h2
`define LEDST_NCH             6
`define LEDST_FRAME_BITS      32
`define LEDST_DC_PERIOD       1280
`define LEDST_PWM_PERIOD      256
`endif

// ==== core/ledst_serial_rx.v ====
// Serial dimming frame receiver: shift on clock rise, load on frame end fall
`timescale 1ns/1ps
`include "ledst_map.vh"
module ledst_serial_rx (
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  input  wire        enable_i,
  input  wire        sclk_i,
  input  wire        sdata_i,
  input  wire        frame_i,
  output reg  [31:0] duty_word_o,
  output reg         load_o
);
  reg  [31:0] shift_q;
  reg         sclk_q;
  reg         frame_q;
  always @(posedge clk_sys_i) begin
    if (sys_rst_i || !enable_i) begin
      shift_q     <= 32'h0;
      sclk_q      <= 1'b0;
      frame_q     <= 1'b0;
      duty_word_o <= 32'h0;
      load_o      <= 1'b0;
    end else begin
      sclk_q  <= sclk_i;
      frame_q <= frame_i;
      load_o  <= 1'b0;
      if (sclk_i && !sclk_q)
        shift_q <= {shift_q[30:0], sdata_i}; // R18
      if (frame_q && !frame_i) begin
        duty_word_o <= shift_q; // R19
        load_o      <= 1'b1;
      end
    end
  end
endmodule

// ==== core/ledst_pwm.v ====
// Counter-compare PWM generator for one dimming group
`timescale 1ns/1ps
`include "ledst_map.vh"
module ledst_pwm #(
  parameter PERIOD = `LEDST_PWM_PERIOD
) (
  input  wire       clk_sys_i,
  input  wire       sys_rst_i,
  input  wire [7:0] duty_i,
  input  wire [10:0] cnt_i,
  output reg        pwm_o
);
  wire [10:0] thr;
  // Code 1 gives 2/256 and code 2 gives 3/256, matching the serial duty curve
  assign thr = (duty_i == 8'h01) ? 11'h002 : ({3'h0, duty_i} + 11'h001);
  always @(posedge clk_sys_i) begin
    if (sys_rst_i)
      pwm_o <= 1'b0;
    else if (PERIOD == `LEDST_PWM_PERIOD)
      // Code zero must give a dark channel, so it is kept out of the threshold curve
      pwm_o <= (duty_i != 8'h00) && (cnt_i[7:0] < thr[8:0]) ? 1'b1 : 1'b0; // R20
    else
      pwm_o <= ({3'h0, duty_i} * 11'h005 + 11'h005) > cnt_i;
  end
endmodule

// ==== core/ledst_top.v ====
// LED startup test, channel enable and dimming mode routing
//
// Notes on behaviour
// R1 - Test current drawn when rail sense ready
// R2 - Test window length is a parameter
// R3 - Low drain sense disables channel, leaves loop
// R4 - Disabled channels stay off until restart
// R5 - Test runs once per startup only
// R6 - Enable low 10 ms restarts whole sequence
// R7 - After test, healthy channels turn on
// R8 - Rail raise request drops at turn-on
// R9 - Three dimming modes chosen by strap
// R10 - Strap ground selects direct PWM
// R11 - Strap open selects serial mode
// R12 - Channel pairs share group dimming
// R13 - Undriven dimming input means off
// R14 - PWM mode inputs active high
// R15 - Source keeps pulses at least 8 us
// R16 - Source keeps frequency at most 488 Hz
// R17 - Strap supply selects DC level mode
// R18 - Serial bit taken on clock rise
// R19 - Frame end fall loads duty bytes
// R20 - Byte order: 01, 23, 4, 5
// R21 - Strap sampled once per start
// R22 - Channels off until test completes
`timescale 1ns/1ps
`include "ledst_map.vh"
module ledst_top #(
  parameter TEST_CYC    = `LEDST_TEST_CYC,
  parameter RESTART_CYC = `LEDST_RESTART_CYC
) (
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  input  wire        chip_enable_i,
  input  wire        rail_ready_i,
  input  wire [5:0]  drain_low_i,
  input  wire [1:0]  mode_strap_i,
  input  wire        dim_group_a_input_i,
  input  wire        dim_group_b_input_i,
  input  wire        dim_ch4_input_i,
  input  wire        dim_ch5_input_i,
  input  wire [7:0]  dc_level_a_i,
  input  wire [7:0]  dc_level_b_i,
  input  wire [7:0]  dc_level_4_i,
  input  wire [7:0]  dc_level_5_i,
  output reg         test_current_o,
  output reg         rail_raise_o,
  output reg  [5:0]  headroom_include_o,
  output reg  [5:0]  ch_on_o,
  output reg  [1:0]  mode_o,
  output reg         run_o
);
  localparam ST_WAIT = 2'h0;
  localparam ST_TEST = 2'h1;
  localparam ST_RUN  = 2'h2;
  localparam ST_OFF  = 2'h3;

  reg  [1:0]  state_q;
  reg  [31:0] cnt_q;
  reg  [5:0]  bad_q;
  reg  [31:0] en_low_q;
  reg  [7:0]  duty_q [0:3];
  reg  [10:0] pcnt_q;
  wire [31:0] rx_word;
  wire        rx_load;
  wire [3:0]  grp_pwm;
  reg  [3:0]  grp;
  wire        restart;
  integer     i;

  // Restart needs enable held low for the full minimum time
  assign restart = (en_low_q >= RESTART_CYC - 1) && !chip_enable_i; // R6

  always @(posedge clk_sys_i) begin
    if (sys_rst_i || chip_enable_i)
      en_low_q <= 32'h0;
    else if (en_low_q < RESTART_CYC)
      en_low_q <= en_low_q + 32'h1;
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i || restart) begin
      state_q        <= ST_WAIT;
      cnt_q          <= 32'h0;
      bad_q          <= 6'h0;
      test_current_o <= 1'b0;
      rail_raise_o   <= 1'b1;
      run_o          <= 1'b0;
      mode_o         <= `LEDST_MODE_PWM;
    end else begin
      case (state_q)
        ST_WAIT: begin
          if (rail_ready_i) begin
            state_q        <= ST_TEST; // R5
            test_current_o <= 1'b1; // R1
            cnt_q          <= 32'h0;
            mode_o         <= (mode_strap_i == `LEDST_MODE_SERIAL) ? `LEDST_MODE_SERIAL : // R21
                              (mode_strap_i == `LEDST_MODE_DC) ? `LEDST_MODE_DC : `LEDST_MODE_PWM; // R9
          end
        end
        ST_TEST: begin
          bad_q <= bad_q | drain_low_i; // R3
          if (cnt_q >= TEST_CYC - 1) begin // R2
            state_q        <= ST_RUN;
            test_current_o <= 1'b0;
            rail_raise_o   <= 1'b0; // R8
            run_o          <= 1'b1; // R7
          end else
            cnt_q <= cnt_q + 32'h1;
        end
        ST_RUN: state_q <= ST_RUN; // R4
        default: state_q <= ST_WAIT;
      endcase
    end
  end

  // Shared period counter; DC mode uses the longer update period
  always @(posedge clk_sys_i) begin
    if (sys_rst_i)
      pcnt_q <= 11'h0;
    else if (pcnt_q >= `LEDST_DC_PERIOD - 1)
      pcnt_q <= 11'h0;
    else
      pcnt_q <= pcnt_q + 11'h1;
  end

  ledst_serial_rx u_rx (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .enable_i    (run_o && mode_o == `LEDST_MODE_SERIAL), // R11
    .sclk_i      (dim_group_b_input_i),
    .sdata_i     (dim_group_a_input_i),
    .frame_i     (dim_ch4_input_i),
    .duty_word_o (rx_word),
    .load_o      (rx_load)
  );

  always @(posedge clk_sys_i) begin
    if (sys_rst_i || restart) begin
      for (i = 0; i < 4; i = i + 1)
        duty_q[i] <= 8'h0;
    end else if (mode_o == `LEDST_MODE_SERIAL && rx_load) begin
      duty_q[0] <= rx_word[31:24]; // R20
      duty_q[1] <= rx_word[23:16];
      duty_q[2] <= rx_word[15:8];
      duty_q[3] <= rx_word[7:0];
    end else if (mode_o == `LEDST_MODE_DC && pcnt_q == 11'h0) begin
      duty_q[0] <= dc_level_a_i; // R17
      duty_q[1] <= dc_level_b_i;
      duty_q[2] <= dc_level_4_i;
      duty_q[3] <= dc_level_5_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pwm
      ledst_pwm #(.PERIOD(`LEDST_PWM_PERIOD)) u_pwm (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .duty_i    (duty_q[g]),
        .cnt_i     (pcnt_q),
        .pwm_o     (grp_pwm[g])
      );
    end
  endgenerate

  always @* begin
    // Pull-downs make an open input read low, so off is the default
    if (mode_o == `LEDST_MODE_PWM) // R10
      grp = {dim_ch5_input_i, dim_ch4_input_i, dim_group_b_input_i, dim_group_a_input_i}; // R14 R13
    else
      grp = grp_pwm;
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i || restart) begin
      ch_on_o            <= 6'h0;
      headroom_include_o <= 6'h0;
    end else if (!run_o) begin
      ch_on_o            <= 6'h0; // R22
      headroom_include_o <= 6'h0;
    end else begin
      headroom_include_o <= ~bad_q; // R3
      ch_on_o <= {grp[3], grp[2], grp[1], grp[1], grp[0], grp[0]} & ~bad_q; // R12 R4
    end
  end
endmodule

// ==== tb/ledst_dim_source.sv ====
// Model of the external dimming controller
`timescale 1ns/1ps
module ledst_dim_source (
  input  wire  clk_sys_i,
  output logic dim_a_o,
  output logic dim_b_o,
  output logic dim_4_o,
  output logic dim_5_o
);
  // Undriven inputs rest low through the pull-downs
  initial {dim_5_o, dim_4_o, dim_b_o, dim_a_o} = 4'h0;
  task automatic levels(input logic [3:0] v);
    @(negedge clk_sys_i);
    {dim_5_o, dim_4_o, dim_b_o, dim_a_o} = v;
  endtask
  // Two cycles a phase so the synchronous sampler sees each edge
  task automatic frame(input logic [31:0] w);
    dim_4_o = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      dim_a_o = w[i];
      repeat (2) @(negedge clk_sys_i);
      dim_b_o = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      dim_b_o = 1'b0;
    end
    dim_a_o = ~w[0];
    dim_4_o = 1'b0;
    repeat (2) @(negedge clk_sys_i);
  endtask
endmodule

// ==== tb/ledst_top_asserts.sv ====
// Port checks for the startup test and dimming block
`timescale 1ns/1ps
module ledst_top_asserts #(
  parameter int TEST_CYC = 20
) (
  input wire       clk_sys_i,
  input wire       sys_rst_i,
  input wire       rail_ready_i,
  input wire       dim_group_a_input_i,
  input wire       dim_group_b_input_i,
  input wire       dim_ch4_input_i,
  input wire       dim_ch5_input_i,
  input wire       test_current_o,
  input wire       rail_raise_o,
  input wire [5:0] headroom_include_o,
  input wire [5:0] ch_on_o,
  input wire [1:0] mode_o,
  input wire       run_o
);
  logic [5:0] want_q;
  always @(posedge clk_sys_i) begin
    want_q <= {dim_ch5_input_i, dim_ch4_input_i, {2{dim_group_b_input_i}}, {2{dim_group_a_input_i}}};
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  test_start_a: assert property ($rose(test_current_o) |-> $past(rail_ready_i) && !run_o)
    else $error("test window opened without ready rail");
  window_len_a: assert property ($rose(test_current_o) |-> ##TEST_CYC (run_o && !test_current_o))
    else $error("test window length wrong");
  dark_early_a: assert property (!run_o |-> ch_on_o == 6'h00)
    else $error("channel on before test end");
  raise_drop_a: assert property ($rose(run_o) |-> $fell(rail_raise_o))
    else $error("rail raise not dropped at turn-on");
  bad_off_a: assert property ((ch_on_o & ~headroom_include_o) == 6'h00)
    else $error("disabled channel conducting");
  once_only_a: assert property (run_o |=> !test_current_o)
    else $error("test repeated while running");
  mode_hold_a: assert property (run_o |=> !run_o || $stable(mode_o))
    else $error("mode changed while running");
  pwm_route_a: assert property (run_o && mode_o == 2'h0 |=> !run_o || ch_on_o == (want_q & headroom_include_o))
    else $error("direct dimming routing wrong");
  cover property ($fell(test_current_o));
  cover property (run_o && mode_o == 2'h1 && ch_on_o[0]);
  cover property (run_o && headroom_include_o != 6'h3f);
endmodule
bind ledst_top ledst_top_asserts #(.TEST_CYC(TEST_CYC)) i_ledst_top_asserts (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .rail_ready_i(rail_ready_i),
  .dim_group_a_input_i(dim_group_a_input_i), .dim_group_b_input_i(dim_group_b_input_i),
  .dim_ch4_input_i(dim_ch4_input_i), .dim_ch5_input_i(dim_ch5_input_i),
  .test_current_o(test_current_o), .rail_raise_o(rail_raise_o), .headroom_include_o(headroom_include_o),
  .ch_on_o(ch_on_o), .mode_o(mode_o), .run_o(run_o));

// ==== tb/test_led_startup_test_and_dim_mode.sv ====
// Self-checking bench for the startup test and dimming block
`timescale 1ns/1ps
`include "ledst_map.vh"
module test_led_startup_test_and_dim_mode;
  logic       clk_sys_i = 1'b0, sys_rst_i = 1'b1, chip_enable_i = 1'b1, rail_ready_i = 1'b0;
  logic [5:0] drain_low_i = 6'h08, ch_on_o, headroom_include_o;
  logic [1:0] mode_strap_i = `LEDST_MODE_PWM, mode_o;
  logic [7:0] dc_a = 8'hff, dc_z = 8'h00;
  logic       a, b, c4, c5, test_current_o, rail_raise_o, run_o;
  logic [9:0] rows [6] = '{10'h000, 10'h043, 10'h084, 10'h110, 10'h220, 10'h3f7};
  int         num_errors = 0, checked = 0;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  ledst_dim_source i_ledst_dim_source (.clk_sys_i(clk_sys_i), .dim_a_o(a), .dim_b_o(b), .dim_4_o(c4), .dim_5_o(c5));
  ledst_top #(.TEST_CYC(20), .RESTART_CYC(50)) i_ledst_top (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .chip_enable_i(chip_enable_i), .rail_ready_i(rail_ready_i),
    .drain_low_i(drain_low_i), .mode_strap_i(mode_strap_i), .dim_group_a_input_i(a), .dim_group_b_input_i(b),
    .dim_ch4_input_i(c4), .dim_ch5_input_i(c5), .dc_level_a_i(dc_a), .dc_level_b_i(dc_z), .dc_level_4_i(dc_z),
    .dc_level_5_i(dc_z), .test_current_o(test_current_o), .rail_raise_o(rail_raise_o),
    .headroom_include_o(headroom_include_o), .ch_on_o(ch_on_o), .mode_o(mode_o), .run_o(run_o));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_run;
    for (int i = 0; i < 100 && run_o !== 1'b1; i++) @(negedge clk_sys_i);
    // Channel enables follow run by one clock
    @(negedge clk_sys_i);
    chk("run", run_o, 1'b1);
  endtask
  task automatic restart(input logic [1:0] m);
    chip_enable_i = 1'b0;
    mode_strap_i = m;
    repeat (55) @(negedge clk_sys_i);
    chk("run", run_o, 1'b0);
    chip_enable_i = 1'b1;
    wait_run();
    chk("mode", mode_o, m);
    chk("include", headroom_include_o, 6'h3f);
  endtask
  // Samples spread over a dimming period so a low duty cannot pass
  task automatic hold_on(input logic [5:0] m, input int n);
    repeat (n) @(negedge clk_sys_i);
    for (int j = 0; j < 4; j++) begin
      repeat (97) @(negedge clk_sys_i);
      chk("ch_on", ch_on_o & m, m);
      chk("ch_off", ch_on_o & ~m, 6'h00);
    end
  endtask
  initial begin
    repeat (3) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    rail_ready_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk("test_current", test_current_o, 1'b1);
    chk("rail_raise", rail_raise_o, 1'b1);
    wait_run();
    chk("include", headroom_include_o, 6'h37);
    chk("rail_raise", rail_raise_o, 1'b0);
    chk("mode", mode_o, `LEDST_MODE_PWM);
    for (int i = 0; i < 6; i++) begin
      i_ledst_dim_source.levels(rows[i][9:6]);
      repeat (`LEDST_PWM_ON_MIN_NS / 10) @(negedge clk_sys_i);
      chk("ch_on", ch_on_o, rows[i][5:0]);
    end
    $display("test direct dimming done");
    rail_ready_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    rail_ready_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    chk("test_current", test_current_o, 1'b0);
    chk("include", headroom_include_o, 6'h37);
    $display("test no retest done");
    drain_low_i = 6'h00;
    restart(`LEDST_MODE_SERIAL);
    i_ledst_dim_source.frame(32'hff00ff00);
    hold_on(6'h13, 0);
    $display("test serial frame done");
    restart(`LEDST_MODE_DC);
    hold_on(6'h03, 1300);
    $display("test level mode done");
    tally_and_finish();
  end
  initial begin
    #200us;
    num_errors++;
    tally_and_finish();
  end
endmodule
